//--- rtl/nsl_defs.vh
// Constants for the network status lamp driver
// Notes on behaviour
// R01: The transmit lamp is pulled low for about 50 ms each time a frame is sent, on either port.
// R02: The receive lamp is pulled low for about 50 ms whenever receive data is seen, on either port.
// R03: The collision lamp is pulled low for about 50 ms whenever a collision is seen, on either port.
// R04: The link lamp shows link status only while its disable input is clear.
// R05: The link lamp is off on the AUI port, and off when link test is on and the link is bad.
// R06: The link lamp is on with twisted pair, link test on and link good, or link test off.
// R07: The polarity lamp is off by default and turns on after seven reversed link pulses or three reversed packets in a row.
// R08: Each activity timer restarts on every new event and holds until 50 ms pass with none.
`ifndef NSL_DEFS_VH
`define NSL_DEFS_VH
`define NSL_CLK_MHZ 100
`define NSL_HOLD_MS 50
`define NSL_HOLD_CYCLES 23'h4c4b40
`define NSL_TMR_W 23
`define NSL_POL_PULSES 3'h7
`define NSL_POL_PACKETS 3'h3
`endif

//--- rtl/nsl_hold_timer.v
// Retriggerable hold timer for one activity lamp
`timescale 1ns/1ns
`include "nsl_defs.vh"
module nsl_hold_timer #(
	parameter [`NSL_TMR_W-1:0] HOLD_CYCLES = `NSL_HOLD_CYCLES
) (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	// Event and lamp
	input wire event_in,
	output reg active_out
);
	reg [`NSL_TMR_W-1:0] count_q;
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_q <= {`NSL_TMR_W{1'b0}};
			active_out <= 1'b0;
		end else if (event_in) begin
			count_q <= HOLD_CYCLES - {{(`NSL_TMR_W-1){1'b0}}, 1'b1}; // [R08]
			active_out <= 1'b1;
		end else if (count_q != {`NSL_TMR_W{1'b0}}) begin
			count_q <= count_q - {{(`NSL_TMR_W-1){1'b0}}, 1'b1};
		end else begin
			active_out <= 1'b0; // [R08]
		end
	end
endmodule

//--- rtl/nsl_led_driver.v
// Status lamp driver: activity, link and polarity lamps
`timescale 1ns/1ns
`include "nsl_defs.vh"
module nsl_led_driver #(
	parameter [`NSL_TMR_W-1:0] HOLD_CYCLES = `NSL_HOLD_CYCLES
) (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	// Event pulses from MAC and transceiver
	input wire tx_frame_in,
	input wire rx_data_in,
	input wire collision_in,
	// Link and configuration
	input wire twisted_pair_port_in,
	input wire link_test_en_in,
	input wire link_good_in,
	input wire link_lamp_disable_in,
	// Polarity events
	input wire link_pulse_in,
	input wire rx_packet_in,
	input wire polarity_reversed_in,
	// Open-drain lamps: pin low when enable high
	output wire transmit_activity_indicator_out,
	output reg transmit_activity_indicator_oe_out,
	output wire receive_activity_indicator_out,
	output reg receive_activity_indicator_oe_out,
	output wire collision_indicator_out,
	output reg collision_indicator_oe_out,
	output wire link_good_indicator_out,
	output reg link_good_indicator_oe_out,
	output wire polarity_reversed_indicator_out,
	output reg polarity_reversed_indicator_oe_out
);

	// ==========================================
	// Run counter and decode helpers
	// ==========================================
	function [2:0] run_next;
		input [2:0] run;
		input strobe;
		input reversed;
		input [2:0] limit;
		begin
			if (!strobe) begin
				run_next = run;
			end else if (!reversed) begin
				run_next = 3'h0;
			end else if (run != limit) begin
				run_next = run + 3'h1;
			end else begin
				run_next = run;
			end
		end
	endfunction

	function run_hit;
		input [2:0] run;
		input strobe;
		input reversed;
		input [2:0] limit;
		begin
			run_hit = strobe && reversed && (run == limit - 3'h1);
		end
	endfunction

	function link_lamp_on;
		input disable_bit;
		input tp_port;
		input test_en;
		input good;
		begin
			link_lamp_on = !disable_bit && tp_port && (!test_en || good);
		end
	endfunction

	// ==========================================
	// Open-drain data is always low
	// ==========================================
	reg drive_low_q;
	assign transmit_activity_indicator_out = drive_low_q;
	assign receive_activity_indicator_out = drive_low_q;
	assign collision_indicator_out = drive_low_q;
	assign link_good_indicator_out = drive_low_q;
	assign polarity_reversed_indicator_out = drive_low_q;

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			drive_low_q <= 1'b0;
		end else begin
			drive_low_q <= 1'b0;
		end
	end

	// ==========================================
	// Activity timers
	// ==========================================
	wire tx_act;
	wire rx_act;
	wire col_act;
	nsl_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_tx (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.event_in(tx_frame_in), // [R01]
		.active_out(tx_act)
	);
	nsl_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_rx (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.event_in(rx_data_in), // [R02]
		.active_out(rx_act)
	);
	nsl_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_col (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.event_in(collision_in), // [R03]
		.active_out(col_act)
	);

	// ==========================================
	// Polarity run counters
	// ==========================================
	reg [2:0] pulse_run_q;
	reg [2:0] pulse_run_d;
	reg [2:0] pkt_run_q;
	reg [2:0] pkt_run_d;
	reg pol_q;
	reg pol_d;
	wire pulse_hit;
	wire pkt_hit;

	assign pulse_hit = run_hit(pulse_run_q, link_pulse_in, polarity_reversed_in,
		`NSL_POL_PULSES);
	assign pkt_hit = run_hit(pkt_run_q, rx_packet_in, polarity_reversed_in,
		`NSL_POL_PACKETS);
	always @* begin
		pulse_run_d = run_next(pulse_run_q, link_pulse_in, polarity_reversed_in,
			`NSL_POL_PULSES);
		pkt_run_d = run_next(pkt_run_q, rx_packet_in, polarity_reversed_in,
			`NSL_POL_PACKETS);
		pol_d = pol_q;
		if (pulse_hit || pkt_hit) begin
			pol_d = 1'b1; // [R07]
		end
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pulse_run_q <= 3'h0;
			pkt_run_q <= 3'h0;
		end else begin
			pulse_run_q <= pulse_run_d;
			pkt_run_q <= pkt_run_d;
		end
	end

	// ==========================================
	// Polarity latch: holds until reset
	// ==========================================
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pol_q <= 1'b0;
		end else begin
			pol_q <= pol_d;
		end
	end

	// ==========================================
	// Lamp enable decode
	// ==========================================
	reg tx_oe_d;
	reg rx_oe_d;
	reg col_oe_d;
	reg link_oe_d;
	reg pol_oe_d;

	always @* begin
		tx_oe_d = tx_act; // [R01]
		rx_oe_d = rx_act; // [R02]
		col_oe_d = col_act; // [R03]
		link_oe_d = link_lamp_on(link_lamp_disable_in, twisted_pair_port_in,
			link_test_en_in, link_good_in); // [R04] [R05] [R06]
		pol_oe_d = pol_q; // [R07]
	end

	// ==========================================
	// Lamp enable registers
	// ==========================================
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			transmit_activity_indicator_oe_out <= 1'b0;
		end else begin
			transmit_activity_indicator_oe_out <= tx_oe_d; // [R01]
		end
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			receive_activity_indicator_oe_out <= 1'b0;
		end else begin
			receive_activity_indicator_oe_out <= rx_oe_d; // [R02]
		end
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			collision_indicator_oe_out <= 1'b0;
		end else begin
			collision_indicator_oe_out <= col_oe_d; // [R03]
		end
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			link_good_indicator_oe_out <= 1'b0;
		end else begin
			link_good_indicator_oe_out <= link_oe_d; // [R05] [R06]
		end
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			polarity_reversed_indicator_oe_out <= 1'b0;
		end else begin
			polarity_reversed_indicator_oe_out <= pol_oe_d; // [R07]
		end
	end
endmodule

//--- bench/nsl_led_driver_chk.sv
// Checker for the status lamp driver
`timescale 1ns/1ns
module nsl_chk (
	input clk_in, resetn_in, tx_frame_in, rx_data_in, collision_in, rx_packet_in,
	input link_pulse_in,
	input twisted_pair_port_in, link_test_en_in, link_good_in, link_lamp_disable_in,
	input polarity_reversed_in, transmit_activity_indicator_oe_out,
	input receive_activity_indicator_oe_out, collision_indicator_oe_out,
	input link_good_indicator_oe_out, polarity_reversed_indicator_oe_out
);
	wire t = transmit_activity_indicator_oe_out, r = receive_activity_indicator_oe_out;
	wire c = collision_indicator_oe_out, l = link_good_indicator_oe_out;
	wire p = polarity_reversed_indicator_oe_out, v = polarity_reversed_in;
	wire f = !link_lamp_disable_in && twisted_pair_port_in && (!link_test_en_in || link_good_in);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	AST_TX_ON: assert property (tx_frame_in |-> ##2 t) else $error("tx");
	AST_RX_HOLD: assert property (rx_data_in |-> ##2 r[*8]) else $error("rx");
	AST_COL_ON: assert property (collision_in |-> ##2 c) else $error("col");
	AST_LINK_DIS: assert property (link_lamp_disable_in |=> !l) else $error("dis");
	AST_LINK_AUI: assert property (!twisted_pair_port_in |=> !l) else $error("aui");
	AST_LINK_EQ: assert property ($past(resetn_in) |-> l == $past(f)) else $error("lk");
	AST_POL_PKT: assert property ((rx_packet_in && v)[*3] |-> ##2 p) else $error("pol");
	AST_POL_STICK: assert property (p |=> p) else $error("stick");
	AST_POL_PULSE: assert property ((link_pulse_in && v)[*7] |-> ##2 p) else $error("pulse");
	AST_TX_CAUSE: assert property ($rose(t) |-> $past(tx_frame_in, 2)) else $error("txc");
	cover property ($fell(t));
	cover property ($rose(l));
	cover property ($rose(p));
endmodule
bind nsl_led_driver nsl_chk chk_u (
	.clk_in(clk_in),
	.resetn_in(resetn_in),
	.tx_frame_in(tx_frame_in),
	.rx_data_in(rx_data_in),
	.collision_in(collision_in),
	.rx_packet_in(rx_packet_in),
	.link_pulse_in(link_pulse_in),
	.twisted_pair_port_in(twisted_pair_port_in),
	.link_test_en_in(link_test_en_in),
	.link_good_in(link_good_in),
	.link_lamp_disable_in(link_lamp_disable_in),
	.polarity_reversed_in(polarity_reversed_in),
	.transmit_activity_indicator_oe_out(transmit_activity_indicator_oe_out),
	.receive_activity_indicator_oe_out(receive_activity_indicator_oe_out),
	.collision_indicator_oe_out(collision_indicator_oe_out),
	.link_good_indicator_oe_out(link_good_indicator_oe_out),
	.polarity_reversed_indicator_oe_out(polarity_reversed_indicator_oe_out)
);

//--- bench/nsl_lamps.sv
// Board lamps on the open-drain lamp pins
`timescale 1ns/1ns
module nsl_lamps (
	input [4:0] oe_in,
	input [4:0] data_in,
	output [4:0] lit_out
);
	// Pin pulled up unless driven; lamp lit while pin is low
	assign lit_out = oe_in & ~data_in;
endmodule

//--- bench/nsl_led_driver_tb.sv
// Testbench for the status lamp driver
`timescale 1ns/1ns
module nsl_led_driver_tb;
	localparam [22:0] H = 23'h14;
	reg clk_in = 0, resetn_in = 0, link_pulse_in = 0, rx_packet_in = 0, polarity_reversed_in = 0;
	reg twisted_pair_port_in = 0, link_test_en_in = 0, link_good_in = 0, link_lamp_disable_in = 0;
	reg [2:0] ev = 0;
	reg [3:0] s;
	wire tx_frame_in = ev[0], rx_data_in = ev[1], collision_in = ev[2];
	wire [4:0] oe, d, lit;
	integer err_count = 0, n_checks = 0, seed = 45900, i, n;
	always #5 clk_in = ~clk_in;
	nsl_led_driver #(.HOLD_CYCLES(H)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
		.tx_frame_in(tx_frame_in), .rx_data_in(rx_data_in), .collision_in(collision_in),
		.twisted_pair_port_in(twisted_pair_port_in), .link_test_en_in(link_test_en_in),
		.link_good_in(link_good_in), .link_lamp_disable_in(link_lamp_disable_in),
		.link_pulse_in(link_pulse_in), .rx_packet_in(rx_packet_in),
		.polarity_reversed_in(polarity_reversed_in),
		.transmit_activity_indicator_out(d[0]), .transmit_activity_indicator_oe_out(oe[0]),
		.receive_activity_indicator_out(d[1]), .receive_activity_indicator_oe_out(oe[1]),
		.collision_indicator_out(d[2]), .collision_indicator_oe_out(oe[2]),
		.link_good_indicator_out(d[3]), .link_good_indicator_oe_out(oe[3]),
		.polarity_reversed_indicator_out(d[4]), .polarity_reversed_indicator_oe_out(oe[4]));
	nsl_lamps lamps_u (.oe_in(oe), .data_in(d), .lit_out(lit));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] %0t got %0d want %0d", $time, got, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	task rst;
		begin
			resetn_in = 0;
			repeat (4) @(negedge clk_in);
			resetn_in = 1;
		end
	endtask
	function integer exp_off(input integer g);
		exp_off = (g > 99 ? 0 : g) + H + 1;
	endfunction
	function exp_link(input [3:0] v);
		exp_link = !v[0] && v[3] && (!v[2] || v[1]);
	endfunction
	task act(input integer k, input integer g);
		begin
			@(negedge clk_in);
			ev = 3'h1 << k;
			@(negedge clk_in);
			ev = 0;
			n = 0;
			while (n < 300 && (n < 3 || lit[k])) begin
				@(negedge clk_in);
				n = n + 1;
				ev = (n == g - 1) ? 3'h1 << k : 3'h0;
				if (n == 2) chk(lit[k], 1);
			end
			chk(n, exp_off(g));
			$display("activity lamp %0d done", k);
			if (n >= 300) finish_test;
		end
	endtask
	task pol(input sel, input integer cnt, input r, input e);
		begin
			repeat (cnt) begin
				{rx_packet_in, link_pulse_in} = sel ? 2'h2 : 2'h1;
				polarity_reversed_in = r;
				@(negedge clk_in);
			end
			{rx_packet_in, link_pulse_in} = 2'h0;
			repeat (2) @(negedge clk_in);
			chk(lit[4], e);
		end
	endtask
	initial begin
		rst;
		for (i = 0; i < 6; i = i + 1) act(i % 3, i < 3 ? 999 : 3 + {$random(seed)} % 18);
		for (i = 0; i < 32; i = i + 1) begin
			s = i < 16 ? i : $random(seed);
			{twisted_pair_port_in, link_test_en_in, link_good_in, link_lamp_disable_in} = s;
			repeat (2) @(negedge clk_in);
			chk(lit[3], exp_link(s));
		end
		$display("link lamp done");
		pol(0, 6, 1, 0); pol(0, 1, 0, 0); pol(0, 6, 1, 0); pol(0, 1, 1, 1);
		rst;
		pol(1, 2, 1, 0); pol(1, 1, 0, 0); pol(1, 2, 1, 0);
		rst;
		pol(0, 7, 1, 1);
		rst;
		pol(1, 3, 1, 1); pol(0, 2, 0, 1);
		$display("polarity lamp done");
		finish_test;
	end
endmodule
